// ===== hw/opvs_top.sv
// One-pin setpoint receiver with switch sequencing, top level
`timescale 1ns/10ps
`include "opvs_consts.svh"

//==============================================================
// Behaviour
// RQ1: Select low: converter 1 uses low-level setpoint, reset 1.2V.
// RQ2: Select high: converter 1 uses high-level setpoint, reset 1.8V.
// RQ3: Each setpoint register is written alone, others untouched.
// RQ4: Fixed frequency: high sides of both converters start half a period apart.
// RQ5: High-side limit: high off, low on, until low-side current clears.
// RQ6: Over-temperature turns both switches off; resumes when indication clears.
// RQ7: Frame is address byte then data byte; accepted only on matching address.
// RQ8: Data byte MSB down: ack request, two select bits, five value bits.
// RQ9: Ack request answered only for a correctly received frame.
// RQ10: Bits decode at any rate 1.7 to 160 kbit/s, no configuration.
// RQ11: Bytes arrive MSB first and are assembled in that order.
// RQ12: Host holds line high before each byte, then falls to start.
// RQ13: Host ends each byte with an end-of-stream low period.
// RQ14: Three setpoint registers of five bits, 32 values each.
// RQ15: Select 00 low-level, 01 high-level, 10 converter 2; 11 unused.
// RQ16: Analog-select version has no high-level register.
// RQ17: Receiver runs only while at least one converter enable is high.
// RQ18: Receiver ready 170 ms after enable; host waits that long.
// RQ19: Each bit spans one falling edge to the next.
// RQ20: One needs high at least 2x low; zero needs low at least 2x high.
// RQ21: Setpoints persist until supply reset, even when disabled.
// RQ22: Forced fixed frequency at once when line high, and throughout reception.
// RQ23: Power save returns only after line low for the 520 us timeout.
// RQ24: Ack needs request, matching address, 16 good bits; pull line low.
// RQ25: A bit meeting neither ratio voids the frame and its ack.

module opvs_top #(
    parameter bit DIGITAL_SELECT = 1'b1,
    // Arbitrary value, set per product
    parameter logic [7:0] DEVICE_ADDR = 8'hA5,
    parameter int unsigned CNT_W = 14,
    parameter int unsigned TIMEOUT_CYCLES = `OPVS_CYCLES_US(`OPVS_TIMEOUT_US),
    parameter int unsigned ACK_CYCLES = `OPVS_CYCLES_US(`OPVS_ACK_US),
    parameter int unsigned STARTUP_CYCLES = `OPVS_CYCLES_MS(`OPVS_STARTUP_MS),
    parameter int unsigned SW_PERIOD = `OPVS_SW_PERIOD
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic mode_data_in,
    output logic ack_pull_out_q,
    output logic ack_pull_oe_q,
    input wire logic conv1_level_select_pin,
    input wire logic conv1_enable_pin,
    input wire logic conv2_enable_pin,
    input wire logic reg_trip1,
    input wire logic reg_trip2,
    input wire logic hs_ilim1,
    input wire logic ls_ilim1,
    input wire logic hs_ilim2,
    input wire logic ls_ilim2,
    input wire logic over_temp,
    output logic [`OPVS_VAL_W-1:0] conv1_setpoint_q,
    output logic [`OPVS_VAL_W-1:0] conv2_setpoint_q,
    output logic forced_pwm_q,
    output logic rx_ready_q,
    output logic hs_on1_q,
    output logic ls_on1_q,
    output logic hs_on2_q,
    output logic ls_on2_q
);

    localparam int unsigned VALACK_CYCLES = `OPVS_CYCLES_US(`OPVS_VALACK_US);
    localparam int unsigned HALF_PERIOD = SW_PERIOD / 2;

    //==============================================================
    // Elaboration checks
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << CNT_W) - 1) begin : g_bad_timeout
        $error("Timeout too large");
    end
    if (ACK_CYCLES < 1 || ACK_CYCLES >= (1 << 14)) begin : g_bad_ack
        $error("Ack length too large");
    end
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << 24)) begin : g_bad_startup
        $error("Startup too large");
    end
    if (SW_PERIOD < 2 || SW_PERIOD > 256 || (SW_PERIOD % 2) != 0) begin : g_bad_period
        $error("Bad switching period");
    end

    //==============================================================
    // Declarations
    opvs_pkg::opvs_rx_state_t state_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] shift_q;
    logic bad_q;
    logic [13:0] wait_cnt_q;
    logic [23:0] start_cnt_q;
    logic [7:0] phase_cnt_q;
    logic [`OPVS_VAL_W-1:0] c1_low_q;
    logic [`OPVS_VAL_W-1:0] c1_high_q;
    logic [`OPVS_VAL_W-1:0] c2_q;
    logic phase1_q;
    logic phase2_q;
    logic bit_fall;
    logic bit_one;
    logic bit_zero;
    logic low_to;
    logic high_to;
    logic rx_enable;
    logic start_done;
    logic valack_done;
    logic ack_done;
    logic last_bit;
    logic frame_good;
    logic wr_en;
    logic receiving;
    logic [7:0] addr_byte;
    logic [7:0] data_byte;
    logic [1:0] sel;

    //==============================================================
    // Bit timing
    opvs_bit_rx #(
        .CNT_W(CNT_W),
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_bit_rx (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .line_in(mode_data_in),
        .fall_q(bit_fall),
        .one_q(bit_one),
        .zero_q(bit_zero),
        .low_to_q(low_to),
        .high_to_q(high_to)
    );

    //==============================================================
    // Frame decode
    assign rx_enable = conv1_enable_pin || conv2_enable_pin; // RQ17
    assign start_done = start_cnt_q == 24'(STARTUP_CYCLES - 1);
    assign valack_done = wait_cnt_q == 14'(VALACK_CYCLES - 1);
    assign ack_done = wait_cnt_q == 14'(ACK_CYCLES - 1);
    // Last bit still sits in the classifier, not yet in the shifter
    assign addr_byte = shift_q[14:7]; // RQ7
    assign data_byte = {shift_q[6:0], bit_one}; // RQ8
    assign sel = {data_byte[`OPVS_SEL_HI_POS], data_byte[`OPVS_SEL_LO_POS]};
    assign last_bit = (state_q == opvs_pkg::rx_bits) && bit_fall && (bit_cnt_q == 5'(`OPVS_FRAME_BITS - 1));
    assign frame_good = !bad_q && (bit_one || bit_zero) && (addr_byte == DEVICE_ADDR); // RQ7 RQ25
    assign wr_en = rx_enable && last_bit && frame_good;
    assign receiving = (state_q == opvs_pkg::rx_bits) || (state_q == opvs_pkg::rx_ack_wait)
        || (state_q == opvs_pkg::rx_ack) || ((state_q == opvs_pkg::rx_idle) && (bit_cnt_q != 5'h00));

    //==============================================================
    // Startup delay after enable
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_cnt_q <= 24'h000000;
        end else if (!rx_enable) begin
            start_cnt_q <= 24'h000000;
        end else if (state_q == opvs_pkg::rx_off && !start_done) begin
            start_cnt_q <= start_cnt_q + 24'h000001; // RQ18
        end
    end

    //==============================================================
    // Receiver state machine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= opvs_pkg::rx_off;
            bit_cnt_q <= 5'h00;
            shift_q <= 16'h0000;
            bad_q <= 1'b0;
            wait_cnt_q <= 14'h0000;
        end else if (!rx_enable) begin // RQ17
            state_q <= opvs_pkg::rx_off;
            bit_cnt_q <= 5'h00;
            bad_q <= 1'b0;
            wait_cnt_q <= 14'h0000;
        end else begin
            case (state_q)
                opvs_pkg::rx_off: begin
                    if (start_done) begin
                        state_q <= opvs_pkg::rx_idle; // RQ18
                    end
                end
                opvs_pkg::rx_idle: begin
                    // A fall here opens a byte, the period before it is start time
                    if (bit_fall) begin // RQ12
                        state_q <= opvs_pkg::rx_bits;
                    end else if (low_to) begin
                        bit_cnt_q <= 5'h00;
                        bad_q <= 1'b0;
                    end
                end
                opvs_pkg::rx_bits: begin
                    if (bit_fall) begin
                        shift_q <= {shift_q[14:0], bit_one}; // RQ11
                        bad_q <= bad_q || !(bit_one || bit_zero); // RQ25
                        if (last_bit) begin
                            bit_cnt_q <= 5'h00;
                            bad_q <= 1'b0;
                            if (frame_good && data_byte[`OPVS_ACK_REQ_POS]) begin // RQ9 RQ24
                                state_q <= opvs_pkg::rx_ack_wait;
                            end else begin
                                state_q <= opvs_pkg::rx_idle;
                            end
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                            if (bit_cnt_q == 5'(`OPVS_BYTE_BITS - 1)) begin
                                state_q <= opvs_pkg::rx_idle; // RQ13
                            end
                        end
                    end else if (low_to || high_to) begin
                        // Stalled line: drop the partial frame
                        state_q <= opvs_pkg::rx_idle;
                        bit_cnt_q <= 5'h00;
                        bad_q <= 1'b0;
                    end
                end
                opvs_pkg::rx_ack_wait: begin
                    if (valack_done) begin
                        state_q <= opvs_pkg::rx_ack;
                        wait_cnt_q <= 14'h0000;
                    end else begin
                        wait_cnt_q <= wait_cnt_q + 14'h0001;
                    end
                end
                opvs_pkg::rx_ack: begin
                    if (ack_done) begin
                        state_q <= opvs_pkg::rx_idle;
                        wait_cnt_q <= 14'h0000;
                    end else begin
                        wait_cnt_q <= wait_cnt_q + 14'h0001;
                    end
                end
                default: begin
                    state_q <= opvs_pkg::rx_off;
                end
            endcase
        end
    end

    //==============================================================
    // Acknowledge pull-down
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_pull_out_q <= 1'b0;
            ack_pull_oe_q <= 1'b0;
            rx_ready_q <= 1'b0;
        end else begin
            ack_pull_out_q <= 1'b0;
            ack_pull_oe_q <= rx_enable && (((state_q == opvs_pkg::rx_ack_wait) && valack_done)
                || ((state_q == opvs_pkg::rx_ack) && !ack_done)); // RQ24
            rx_ready_q <= rx_enable && (state_q != opvs_pkg::rx_off);
        end
    end

    //==============================================================
    // Setpoint registers, returned to their reset codes only by supply reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin // RQ21
            c1_low_q <= `OPVS_C1_LOW_RESET;
            c1_high_q <= `OPVS_C1_HIGH_RESET;
            c2_q <= `OPVS_C2_RESET;
        end else if (wr_en) begin // RQ3 RQ14
            if (sel == `OPVS_SEL_C1_LOW) begin // RQ15
                c1_low_q <= data_byte[`OPVS_VAL_MSB:0];
            end else if (sel == `OPVS_SEL_C1_HIGH && DIGITAL_SELECT) begin // RQ16
                c1_high_q <= data_byte[`OPVS_VAL_MSB:0];
            end else if (sel == `OPVS_SEL_C2) begin
                c2_q <= data_byte[`OPVS_VAL_MSB:0];
            end
        end
    end

    //==============================================================
    // Active setpoints
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv1_setpoint_q <= `OPVS_C1_LOW_RESET;
            conv2_setpoint_q <= `OPVS_C2_RESET;
        end else begin
            conv1_setpoint_q <= (DIGITAL_SELECT && conv1_level_select_pin) ? c1_high_q : c1_low_q; // RQ1 RQ2
            conv2_setpoint_q <= c2_q;
        end
    end

    //==============================================================
    // Mode selection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            forced_pwm_q <= 1'b0;
        end else begin
            // Long low wins only outside a frame, so an ack never drops the mode
            forced_pwm_q <= mode_data_in || receiving || !low_to; // RQ22 RQ23
        end
    end

    //==============================================================
    // Interleaved phase starts
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_cnt_q <= 8'h00;
            phase1_q <= 1'b0;
            phase2_q <= 1'b0;
        end else begin
            phase_cnt_q <= (phase_cnt_q == 8'(SW_PERIOD - 1)) ? 8'h00 : phase_cnt_q + 8'h01;
            phase1_q <= phase_cnt_q == 8'h00; // RQ4
            phase2_q <= phase_cnt_q == 8'(HALF_PERIOD); // RQ4
        end
    end

    //==============================================================
    // Power switches
    opvs_switch_ctl u_sw1 (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .enable(conv1_enable_pin),
        .phase_start(phase1_q),
        .off_trip(reg_trip1),
        .hs_ilim(hs_ilim1),
        .ls_ilim(ls_ilim1),
        .over_temp(over_temp),
        .hs_on_q(hs_on1_q),
        .ls_on_q(ls_on1_q)
    );

    opvs_switch_ctl u_sw2 (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .enable(conv2_enable_pin),
        .phase_start(phase2_q),
        .off_trip(reg_trip2),
        .hs_ilim(hs_ilim2),
        .ls_ilim(ls_ilim2),
        .over_temp(over_temp),
        .hs_on_q(hs_on2_q),
        .ls_on_q(ls_on2_q)
    );

endmodule // opvs_top

// ===== hw/opvs_consts.svh
// Constants of the one-pin setpoint receiver
`ifndef OPVS_CONSTS_SVH
`define OPVS_CONSTS_SVH

//==============================================================
// Clock and times
`define OPVS_CLK_MHZ 10
`define OPVS_TIMEOUT_US 520
`define OPVS_ACK_US 520
`define OPVS_VALACK_US 2
`define OPVS_STARTUP_MS 170
`define OPVS_CYCLES_US(t) ((t) * `OPVS_CLK_MHZ)
`define OPVS_CYCLES_MS(t) ((t) * 1000 * `OPVS_CLK_MHZ)
`define OPVS_SW_PERIOD 16

//==============================================================
// Frame layout
`define OPVS_BYTE_BITS 8
`define OPVS_FRAME_BITS 16
`define OPVS_ACK_REQ_POS 7
`define OPVS_SEL_HI_POS 6
`define OPVS_SEL_LO_POS 5
`define OPVS_VAL_MSB 4
`define OPVS_VAL_W 5

//==============================================================
// Register select codes
`define OPVS_SEL_C1_LOW 2'h0
`define OPVS_SEL_C1_HIGH 2'h1
`define OPVS_SEL_C2 2'h2

//==============================================================
// Reset codes of the setpoints
`define OPVS_C1_LOW_RESET 5'h0C
`define OPVS_C1_HIGH_RESET 5'h18
`define OPVS_C2_RESET 5'h10

`endif

// ===== hw/opvs_pkg.sv
// Types of the one-pin setpoint receiver
package opvs_pkg;

    //==============================================================
    // Receiver states
    typedef enum logic [2:0] {
        rx_off,
        rx_idle,
        rx_bits,
        rx_ack_wait,
        rx_ack
    } opvs_rx_state_t;

endpackage

// ===== hw/opvs_bit_rx.sv
// Bit timer and classifier of the one-pin line
`timescale 1ns/10ps

module opvs_bit_rx #(
    parameter int unsigned CNT_W = 14,
    parameter int unsigned TIMEOUT_CYCLES = 5200
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic line_in,
    output logic fall_q,
    output logic one_q,
    output logic zero_q,
    output logic low_to_q,
    output logic high_to_q
);

    localparam logic [CNT_W-1:0] TO_CNT = CNT_W'(TIMEOUT_CYCLES);

    logic line_prev_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] high_cnt_q;
    logic fall;

    // Ratio test without a divider
    function automatic logic twice(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
        return {1'b0, a} >= {b, 1'b0};
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] a);
        return (&a) ? a : a + CNT_W'(1);
    endfunction

    assign fall = line_prev_q && !line_in;

    //==============================================================
    // Phase counters, restarted by each falling edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_prev_q <= 1'b0;
            low_cnt_q <= '0;
            high_cnt_q <= '0;
        end else begin
            line_prev_q <= line_in;
            if (fall) begin // RQ19
                low_cnt_q <= CNT_W'(1);
                high_cnt_q <= '0;
            end else if (!line_in) begin
                low_cnt_q <= sat_inc(low_cnt_q);
            end else begin
                high_cnt_q <= sat_inc(high_cnt_q);
            end
        end
    end

    //==============================================================
    // Decision on the closed period
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fall_q <= 1'b0;
            one_q <= 1'b0;
            zero_q <= 1'b0;
            low_to_q <= 1'b0;
            high_to_q <= 1'b0;
        end else begin
            fall_q <= fall;
            one_q <= fall && twice(high_cnt_q, low_cnt_q); // RQ10 RQ20
            zero_q <= fall && twice(low_cnt_q, high_cnt_q); // RQ20
            low_to_q <= !line_in && !fall && (low_cnt_q >= TO_CNT);
            high_to_q <= line_in && (high_cnt_q >= TO_CNT);
        end
    end

endmodule // opvs_bit_rx

// ===== hw/opvs_switch_ctl.sv
// Gate sequencing of one converter's power switches
`timescale 1ns/10ps

module opvs_switch_ctl (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic phase_start,
    input wire logic off_trip,
    input wire logic hs_ilim,
    input wire logic ls_ilim,
    input wire logic over_temp,
    output logic hs_on_q,
    output logic ls_on_q
);

    logic blocked_q;

    //==============================================================
    // High side, low side and current-limit hold
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_on_q <= 1'b0;
            ls_on_q <= 1'b0;
            blocked_q <= 1'b0;
        end else if (!enable || over_temp) begin // RQ6
            hs_on_q <= 1'b0;
            ls_on_q <= 1'b0;
            blocked_q <= 1'b0;
        end else if (hs_on_q && hs_ilim) begin // RQ5
            hs_on_q <= 1'b0;
            ls_on_q <= 1'b1;
            blocked_q <= 1'b1;
        end else if (blocked_q) begin
            // High side waits for the first phase start after ls_ilim clears
            ls_on_q <= 1'b1;
            blocked_q <= ls_ilim; // RQ5
        end else if (phase_start) begin // RQ4
            hs_on_q <= 1'b1;
            ls_on_q <= 1'b0;
        end else if (hs_on_q && off_trip) begin
            hs_on_q <= 1'b0;
            ls_on_q <= 1'b1;
        end
    end

endmodule // opvs_switch_ctl

// ===== verification/opvs_monitor.sv
// Port checker of the one-pin setpoint receiver
`timescale 1ns/10ps
`include "opvs_consts.svh"

module opvs_monitor #(
    parameter int unsigned TIMEOUT_CYCLES = 5200
) (
    input logic core_clk,
    input logic reset_n,
    input logic mode_data_in,
    input logic ack_pull_out_q,
    input logic ack_pull_oe_q,
    input logic conv1_enable_pin,
    input logic conv2_enable_pin,
    input logic hs_ilim1,
    input logic ls_ilim1,
    input logic over_temp,
    input logic [`OPVS_VAL_W-1:0] conv2_setpoint_q,
    input logic forced_pwm_q,
    input logic rx_ready_q,
    input logic hs_on1_q,
    input logic ls_on1_q,
    input logic hs_on2_q,
    input logic ls_on2_q
);
    logic [15:0] low_cnt_q;
    logic held_q;
    logic en_any;
    assign en_any = conv1_enable_pin | conv2_enable_pin;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    //==========
    // Helper state
    // Saturates, so a long low never wraps
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_q <= 16'h0000;
        end else if (mode_data_in) begin
            low_cnt_q <= 16'h0000;
        end else if (low_cnt_q != 16'hFFFF) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            held_q <= 1'b0;
        end else if (hs_on1_q && hs_ilim1) begin
            held_q <= 1'b1;
        end else if (!ls_ilim1) begin
            held_q <= 1'b0;
        end
    end

    //==========
    // Assertions
    a_ack_pull_low: assert property (ack_pull_oe_q |-> !ack_pull_out_q)
        else $error("ack drives high");
    a_ack_len: assert property ($rose(ack_pull_oe_q) |-> ack_pull_oe_q[*8])
        else $error("ack too short");
    a_ack_ready: assert property ($rose(ack_pull_oe_q) |-> rx_ready_q)
        else $error("ack while off");
    a_pwm_on_high: assert property (mode_data_in |=> forced_pwm_q)
        else $error("forced mode late");
    a_pwm_off_late: assert property ($fell(forced_pwm_q) |-> low_cnt_q + 2 >= TIMEOUT_CYCLES)
        else $error("power save early");
    a_thermal_off: assert property (over_temp |=> !(hs_on1_q || ls_on1_q || hs_on2_q || ls_on2_q))
        else $error("switch on when hot");
    a_ilim_swap: assert property (hs_on1_q && hs_ilim1 && !over_temp && conv1_enable_pin |=> !hs_on1_q && ls_on1_q)
        else $error("limit not handled");
    a_ilim_hold: assert property (held_q && ls_ilim1 |-> !hs_on1_q)
        else $error("high side in limit");
    a_phase_apart: assert property (!($rose(hs_on1_q) && $rose(hs_on2_q)))
        else $error("high sides together");
    a_sp_quiet: assert property ($changed(conv2_setpoint_q) |-> !mode_data_in && !$past(mode_data_in, 2))
        else $error("setpoint moved early");
    a_ready_needs_en: assert property (rx_ready_q |-> $past(en_any, 2))
        else $error("ready while disabled");
endmodule // opvs_monitor

bind opvs_top opvs_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) opvs_monitor_i (
    .core_clk, .reset_n, .mode_data_in, .ack_pull_out_q, .ack_pull_oe_q, .conv1_enable_pin, .conv2_enable_pin,
    .hs_ilim1, .ls_ilim1, .over_temp, .conv2_setpoint_q, .forced_pwm_q, .rx_ready_q, .hs_on1_q, .ls_on1_q,
    .hs_on2_q, .ls_on2_q
);

// ===== verification/opvs_host_model.sv
// Host controller model on the shared open-drain line
`timescale 1ns/10ps

module opvs_host_model (
    input wire logic core_clk,
    output logic line_q
);
    // High is released, pull-up level
    initial line_q = 1'b1;

    task automatic hold(input logic v, input int n);
        line_q <= v;
        repeat (n) @(posedge core_clk);
    endtask

    //==========
    // Byte sender; unit scales each bit's low and high phases, not the lead-in high or the end low
    task automatic send_byte(input logic [7:0] b, input int unit, input int bad);
        hold(1'b1, 10);
        for (int i = 7; i >= 0; i--) begin
            if (i == bad) begin
                hold(1'b0, 6 * unit);
                hold(1'b1, 6 * unit);
            end else begin
                hold(1'b0, (b[i] ? 3 : 9) * unit);
                hold(1'b1, (b[i] ? 9 : 3) * unit);
            end
        end
        hold(1'b0, 24);
    endtask
endmodule // opvs_host_model

// ===== verification/tb_opvs_top.sv
// Bench of the one-pin setpoint receiver
`timescale 1ns/10ps
`include "opvs_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb_opvs_top;
    // Arbitrary device address
    localparam logic [7:0] ADDR = 8'hA5;
    logic core_clk, reset_n, sel, en1, en2, trip1, trip2, hs_ilim1, ls_ilim1, over_temp;
    logic [4:0] conv1_setpoint_q, conv2_setpoint_q;
    logic ack_out, ack_oe, forced_pwm_q, rx_ready_q, hs_on1_q, ls_on1_q, hs_on2_q, ls_on2_q;
    wire logic host_line, line_w;
    int fails = 0, checks_done = 0;
    logic [4:0] sp [3] = '{`OPVS_C1_LOW_RESET, `OPVS_C1_HIGH_RESET, `OPVS_C2_RESET};
    assign line_w = ack_oe ? ack_out : host_line;

    opvs_top #(.DEVICE_ADDR(ADDR), .TIMEOUT_CYCLES(60), .ACK_CYCLES(20), .STARTUP_CYCLES(50)) opvs_top_i (
        .core_clk, .reset_n, .mode_data_in(line_w), .ack_pull_out_q(ack_out), .ack_pull_oe_q(ack_oe),
        .conv1_level_select_pin(sel), .conv1_enable_pin(en1), .conv2_enable_pin(en2), .reg_trip1(trip1),
        .reg_trip2(trip2), .hs_ilim1, .ls_ilim1, .hs_ilim2(1'b0), .ls_ilim2(1'b0), .over_temp, .conv1_setpoint_q,
        .conv2_setpoint_q, .forced_pwm_q, .rx_ready_q, .hs_on1_q, .ls_on1_q, .hs_on2_q, .ls_on2_q
    );
    opvs_host_model host_i (.core_clk(core_clk), .line_q(host_line));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Regulator stand-in, trips a cycle after turn-on
    always @(posedge core_clk) begin
        trip1 <= hs_on1_q;
        trip2 <= hs_on2_q;
    end

    //==========
    // Shared tasks
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check_sp();
        for (int s = 0; s < 2; s++) begin
            sel <= s[0];
            repeat (3) @(posedge core_clk);
            `CHK(conv1_setpoint_q, sp[s])
        end
        `CHK(conv2_setpoint_q, sp[2])
    endtask

    task automatic frame(input logic [15:0] f, input int bad, input int unit, input logic ack);
        host_i.send_byte(f[15:8], unit, -1);
        host_i.send_byte(f[7:0], unit, bad);
        host_i.hold(1'b1, 4);
        `CHK(line_w, !ack)
        host_i.hold(1'b1, 60);
    endtask

    task automatic wait_rise1();
        do @(negedge core_clk); while (hs_on1_q !== 1'b0);
        do @(negedge core_clk); while (hs_on1_q !== 1'b1);
    endtask

    //==========
    // Scenarios
    task automatic t_start();
        repeat (40) @(posedge core_clk);
        `CHK(rx_ready_q, 1'b0)
        repeat (20) @(posedge core_clk);
        `CHK(rx_ready_q, 1'b1)
    endtask

    task automatic t_mode();
        `CHK(forced_pwm_q, 1'b1)
        host_i.hold(1'b0, 40);
        `CHK(forced_pwm_q, 1'b1)
        host_i.hold(1'b0, 30);
        `CHK(forced_pwm_q, 1'b0)
        host_i.hold(1'b1, 2);
        `CHK(forced_pwm_q, 1'b1)
        host_i.hold(1'b1, 20);
    endtask

    task automatic t_frames();
        logic [15:0] tf [8] = '{16'hA595, 16'hA5AA, 16'hA5DF, 16'hA481, 16'hA5E2, 16'hA5C3, 16'hA544, 16'hA587};
        int bad;
        logic wr;
        for (int i = 0; i < 8; i++) begin
            bad = (i == 5) ? 2 : -1;
            wr = tf[i][15:8] == ADDR && bad < 0 && tf[i][6:5] != 2'h3;
            frame(tf[i], bad, (i == 7) ? 2 : 1, tf[i][15:8] == ADDR && bad < 0 && tf[i][7]);
            if (wr) sp[tf[i][6:5]] = tf[i][4:0];
            check_sp();
        end
    endtask

    task automatic t_phase();
        wait_rise1();
        repeat (7) @(negedge core_clk);
        `CHK({hs_on1_q, hs_on2_q}, 2'b00)
        @(negedge core_clk);
        `CHK({hs_on1_q, hs_on2_q}, 2'b01)
    endtask

    task automatic t_ilim();
        logic seen = 1'b0;
        wait_rise1();
        @(posedge core_clk);
        {hs_ilim1, ls_ilim1} <= 2'h3;
        @(posedge core_clk);
        hs_ilim1 <= 1'b0;
        repeat (40) @(negedge core_clk) seen |= hs_on1_q;
        `CHK(seen, 1'b0)
        @(posedge core_clk);
        ls_ilim1 <= 1'b0;
        repeat (20) @(negedge core_clk) seen |= hs_on1_q;
        `CHK(seen, 1'b1)
    endtask

    task automatic t_thermal();
        logic seen = 1'b0;
        @(posedge core_clk);
        over_temp <= 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK({hs_on1_q, ls_on1_q, hs_on2_q, ls_on2_q}, 4'h0)
        @(posedge core_clk);
        over_temp <= 1'b0;
        repeat (20) @(negedge core_clk) seen |= hs_on1_q;
        `CHK(seen, 1'b1)
    endtask

    task automatic t_enable();
        @(posedge core_clk);
        {en1, en2} <= 2'h0;
        repeat (3) @(posedge core_clk);
        `CHK({rx_ready_q, hs_on1_q, hs_on2_q}, 3'h0)
        frame(16'hA5DE, -1, 1, 1'b0);
        check_sp();
        en2 <= 1'b1;
        t_start();
        frame(16'hA59B, -1, 1, 1'b1);
        sp[0] = 5'h1B;
        check_sp();
        en1 <= 1'b1;
    endtask

    //==========
    // Main sequence and watchdog
    initial begin
        reset_n = 1'b0;
        {sel, hs_ilim1, ls_ilim1, over_temp} = 4'h0;
        {en1, en2} = 2'h3;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        check_sp();
        t_start();
        t_mode();
        t_frames();
        t_phase();
        t_ilim();
        t_thermal();
        t_enable();
        tally_and_finish();
    end

    // Several times the run length
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end
endmodule // tb_opvs_top
